// >>> verilog/glcs_pkg.sv
// Constants shared by the gate-2 input select block
package glcs_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned N_LINES   = 4;
  localparam int unsigned SEL_W     = 2 * N_LINES;
  localparam int unsigned BUS_DW    = 32;

  // ---------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int unsigned IDX_SELECT = 0;
  localparam int unsigned IDX_STATUS = 1;

  // ---------------------------------------------------------------
  // Select register fields (odd bit true form, even bit inverted)
  // ---------------------------------------------------------------
  localparam int unsigned B_IN3_TRUE = 7;
  localparam int unsigned B_IN3_INV  = 6;
  localparam int unsigned B_IN2_TRUE = 5;
  localparam int unsigned B_IN2_INV  = 4;
  localparam int unsigned B_IN1_TRUE = 3;
  localparam int unsigned B_IN1_INV  = 2;
  localparam int unsigned B_IN0_TRUE = 1;
  localparam int unsigned B_IN0_INV  = 0;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int unsigned ST_LINE_LSB = 0;
  localparam int unsigned ST_TERM_LSB = 8;
  localparam int unsigned ST_TOP_BIT  = 15;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0]   SEL_RST   = 8'h00;
  localparam logic [SEL_W-1:0]   TERM_RST  = 8'h00;
  localparam logic [N_LINES-1:0] LINE_RST  = 4'h0;
  localparam logic [BUS_DW-1:0]  DAT_RST   = 32'h0000_0000;

endpackage : glcs_pkg

// >>> verilog/glcs_term_gate.sv
// Per-line true and inverted gating of the cell input lines into gate 2
`timescale 1ns/100ps
`default_nettype none

module glcs_term_gate #(
  parameter int unsigned N_IN = 4
) (
  input  wire logic [2*N_IN-1:0] i_select,
  input  wire logic [N_IN-1:0]   i_line,
  output logic      [2*N_IN-1:0] o_terms
);

  // ---------------------------------------------------------------
  // Gating
  // ---------------------------------------------------------------
  // Both polarities of one line may be enabled at once; the term pair
  // then carries the line and its complement, left for the gate to combine.
  for (genvar g = 0; g < N_IN; g++) begin : g_line
    assign o_terms[2*g+1] = i_select[2*g+1] & i_line[g];
    assign o_terms[2*g]   = i_select[2*g] & ~i_line[g];
  end

endmodule : glcs_term_gate

`default_nettype wire

// >>> verilog/glcs_gate2_select.sv
// Gate-2 input select register with a classic Wishbone slave
//
// How it works
// - Bit 7 gates true line 3 in
// - Bit 6 gates inverted line 3 in
// - Bit 5 gates true line 2 in
// - Bit 4 gates inverted line 2 in
// - Bit 3 gates true line 1 in
// - Bit 2 gates inverted line 1 in
// - Bit 1 gates true line 0 in
// - Bit 0 gates inverted line 0 in
// - Bits read/write; other resets keep them
`timescale 1ns/100ps
`default_nettype none

module glcs_gate2_select #(
  parameter int unsigned ADR_W  = 4,
  parameter int unsigned DATA_W = 32
) (
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_other_rst,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADR_W-1:0]  i_wb_adr,
  input  wire logic [DATA_W/8-1:0] i_wb_sel,
  input  wire logic [DATA_W-1:0] i_wb_dat,
  input  wire logic [3:0]        i_cell_input_line,
  output logic                   o_wb_ack,
  output logic      [DATA_W-1:0] o_wb_dat,
  output logic      [7:0]        o_gate2_terms,
  output logic      [7:0]        o_gate2_input_select
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (ADR_W < 3) begin : g_bad_adr
    $error("ADR_W must hold at least two word indices");
  end
  if (DATA_W != glcs_pkg::BUS_DW) begin : g_bad_dat
    $error("DATA_W must be 32");
  end

  localparam int unsigned WI_W = ADR_W - 2;
  localparam int unsigned SW   = glcs_pkg::SEL_W;
  localparam int unsigned NL   = glcs_pkg::N_LINES;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
    logic [SW-1:0]     sel;
    logic [NL-1:0]     line;
    logic [SW-1:0]     terms;
  } glcs_state_t;

  localparam glcs_state_t ST_RST = '{
    ack:   1'b0,
    dat:   glcs_pkg::DAT_RST,
    sel:   glcs_pkg::SEL_RST,
    line:  glcs_pkg::LINE_RST,
    terms: glcs_pkg::TERM_RST
  };

  glcs_state_t   st_r;
  glcs_state_t   st_nxt;
  logic [SW-1:0] terms_now;

  // Word index match; low two address bits are ignored
  function automatic logic glcs_hit(input logic [ADR_W-1:0] adr,
                                    input int unsigned      idx);
    return adr[ADR_W-1:2] == WI_W'(idx);
  endfunction : glcs_hit

  function automatic logic [DATA_W-1:0] glcs_read(input logic [ADR_W-1:0] adr,
                                                  input glcs_state_t      s);
    logic [DATA_W-1:0] w;
    w = glcs_pkg::DAT_RST;
    if (glcs_hit(adr, glcs_pkg::IDX_SELECT)) begin
      w[SW-1:0] = s.sel;
    end else if (glcs_hit(adr, glcs_pkg::IDX_STATUS)) begin
      w[glcs_pkg::ST_LINE_LSB +: NL] = s.line;
      w[glcs_pkg::ST_TERM_LSB +: SW] = s.terms;
    end
    return w;
  endfunction : glcs_read

  // ---------------------------------------------------------------
  // Gating of the cell input lines
  // ---------------------------------------------------------------
  glcs_term_gate #(
    .N_IN (NL)
  ) u_term_gate (
    .i_select (st_r.sel),
    .i_line   (i_cell_input_line),
    .o_terms  (terms_now)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.line  = i_cell_input_line;
    st_nxt.terms = terms_now;
    st_nxt.ack   = i_wb_cyc & i_wb_stb & ~st_r.ack;
    if (i_wb_cyc & i_wb_stb & ~st_r.ack) begin
      st_nxt.dat = glcs_read(i_wb_adr, st_r);
    end
    // Write lands on the edge where the master sees ack
    if (i_wb_cyc & i_wb_stb & st_r.ack & i_wb_we & i_wb_sel[0]
        & glcs_hit(i_wb_adr, glcs_pkg::IDX_SELECT)) begin
      st_nxt.sel = i_wb_dat[SW-1:0];
    end
    // A lesser reset aborts the bus cycle but keeps the selection
    if (i_other_rst) begin
      st_nxt.ack = 1'b0;
      st_nxt.dat = glcs_pkg::DAT_RST;
      st_nxt.sel = st_r.sel;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_wb_ack             = st_r.ack;
  assign o_wb_dat             = st_r.dat;
  assign o_gate2_terms        = st_r.terms;
  assign o_gate2_input_select = st_r.sel;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // First cycle out of reset has no valid history for the term checks
  sequence out_of_rst;
    !$past(i_sys_rst);
  endsequence

  property p_in3_true;
    out_of_rst |->
      o_gate2_terms[glcs_pkg::B_IN3_TRUE] ==
      ($past(o_gate2_input_select[glcs_pkg::B_IN3_TRUE]) && $past(i_cell_input_line[3]));
  endproperty
  a_in3_true: assert property (p_in3_true)
    else $error("gate2 true term of line 3 wrong");

  property p_in3_inv;
    (o_gate2_input_select[glcs_pkg::B_IN3_INV] && !i_cell_input_line[3])
      |=> o_gate2_terms[glcs_pkg::B_IN3_INV];
  endproperty
  a_in3_inv: assert property (p_in3_inv)
    else $error("gate2 inverted term of line 3 missing");

  property p_in3_inv_off;
    (!o_gate2_input_select[glcs_pkg::B_IN3_INV] || i_cell_input_line[3])
      |=> !o_gate2_terms[glcs_pkg::B_IN3_INV];
  endproperty
  a_in3_inv_off: assert property (p_in3_inv_off)
    else $error("gate2 inverted term of line 3 leaks");

  property p_in2_true;
    out_of_rst |->
      o_gate2_terms[glcs_pkg::B_IN2_TRUE] ==
      ($past(o_gate2_input_select[glcs_pkg::B_IN2_TRUE]) & $past(i_cell_input_line[2]));
  endproperty
  a_in2_true: assert property (p_in2_true)
    else $error("gate2 true term of line 2 wrong");

  property p_in2_inv;
    out_of_rst |->
      o_gate2_terms[glcs_pkg::B_IN2_INV] ==
      ($past(o_gate2_input_select[glcs_pkg::B_IN2_INV]) & !$past(i_cell_input_line[2]));
  endproperty
  a_in2_inv: assert property (p_in2_inv)
    else $error("gate2 inverted term of line 2 wrong");

  property p_in1_true;
    !o_gate2_input_select[glcs_pkg::B_IN1_TRUE] |=> !o_gate2_terms[glcs_pkg::B_IN1_TRUE];
  endproperty
  a_in1_true: assert property (p_in1_true)
    else $error("gate2 true term of line 1 leaks");

  property p_in1_true_on;
    (o_gate2_input_select[glcs_pkg::B_IN1_TRUE] && i_cell_input_line[1])
      |=> o_gate2_terms[glcs_pkg::B_IN1_TRUE];
  endproperty
  a_in1_true_on: assert property (p_in1_true_on)
    else $error("gate2 true term of line 1 missing");

  property p_in1_inv;
    out_of_rst |->
      o_gate2_terms[glcs_pkg::B_IN1_INV] ==
      ($past(o_gate2_input_select[glcs_pkg::B_IN1_INV]) & !$past(i_cell_input_line[1]));
  endproperty
  a_in1_inv: assert property (p_in1_inv)
    else $error("gate2 inverted term of line 1 wrong");

  property p_in0_true;
    out_of_rst |->
      o_gate2_terms[glcs_pkg::B_IN0_TRUE] ==
      ($past(o_gate2_input_select[glcs_pkg::B_IN0_TRUE]) & $past(i_cell_input_line[0]));
  endproperty
  a_in0_true: assert property (p_in0_true)
    else $error("gate2 true term of line 0 wrong");

  property p_in0_inv;
    out_of_rst |->
      o_gate2_terms[glcs_pkg::B_IN0_INV] ==
      ($past(o_gate2_input_select[glcs_pkg::B_IN0_INV]) & !$past(i_cell_input_line[0]));
  endproperty
  a_in0_inv: assert property (p_in0_inv)
    else $error("gate2 inverted term of line 0 wrong");

  // Bus sequences
  sequence s_sel_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack && !i_other_rst
      && glcs_hit(i_wb_adr, glcs_pkg::IDX_SELECT);
  endsequence

  sequence s_sel_write_done;
    i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we && i_wb_sel[0] && !i_other_rst
      && glcs_hit(i_wb_adr, glcs_pkg::IDX_SELECT);
  endsequence

  property p_write_sel;
    logic [7:0] wd;
    (s_sel_write_done, wd = i_wb_dat[7:0]) |=> o_gate2_input_select == wd;
  endproperty
  a_write_sel: assert property (p_write_sel)
    else $error("select write not stored");

  property p_read_sel;
    (s_sel_req and !i_wb_we) ##1 o_wb_ack |->
      o_wb_dat == {{(DATA_W-8){1'b0}}, o_gate2_input_select};
  endproperty
  a_read_sel: assert property (p_read_sel)
    else $error("select readback wrong");

  property p_other_rst_keep;
    i_other_rst |=> $stable(o_gate2_input_select) && !o_wb_ack;
  endproperty
  a_other_rst_keep: assert property (p_other_rst_keep)
    else $error("lesser reset disturbed selection");

  property p_no_write_keep;
    !(i_wb_cyc && i_wb_stb && o_wb_ack && i_wb_we) |=> $stable(o_gate2_input_select);
  endproperty
  a_no_write_keep: assert property (p_no_write_keep)
    else $error("selection changed without a write");

  property p_ack_pulse;
    o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_ack_latency;
    (i_wb_cyc && i_wb_stb && !o_wb_ack && !i_other_rst) |=> o_wb_ack;
  endproperty
  a_ack_latency: assert property (p_ack_latency)
    else $error("ack not given one cycle after request");

  // Unmapped words answer zero so software can probe the map safely
  property p_read_other_zero;
    (i_wb_cyc && i_wb_stb && !o_wb_ack && !i_other_rst
      && !glcs_hit(i_wb_adr, glcs_pkg::IDX_SELECT)
      && !glcs_hit(i_wb_adr, glcs_pkg::IDX_STATUS)) |=> o_wb_dat == glcs_pkg::DAT_RST;
  endproperty
  a_read_other_zero: assert property (p_read_other_zero)
    else $error("unmapped word did not read zero");

  sequence s_status_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack && !i_other_rst
      && glcs_hit(i_wb_adr, glcs_pkg::IDX_STATUS);
  endsequence

  property p_read_status;
    s_status_req |=>
      o_wb_dat[glcs_pkg::ST_TERM_LSB +: SW] == $past(o_gate2_terms)
      && o_wb_dat[glcs_pkg::ST_LINE_LSB +: NL] == $past(i_cell_input_line, 2);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status readback wrong");

  property p_misdirected_write_keep;
    (i_wb_cyc && i_wb_stb && (!i_wb_sel[0] || !glcs_hit(i_wb_adr, glcs_pkg::IDX_SELECT)))
      |=> $stable(o_gate2_input_select);
  endproperty
  a_misdirected_write_keep: assert property (p_misdirected_write_keep)
    else $error("selection changed by a write elsewhere");

  property p_ack_needs_req;
    o_wb_ack |-> $past(i_wb_cyc && i_wb_stb && !i_other_rst);
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req)
    else $error("ack without a request");

endmodule : glcs_gate2_select

`default_nettype wire

// >>> test/glcs_gate2_select_test.sv
// Self-checking bench for the gate-2 input select block
`timescale 1ns/100ps
`default_nettype none

module glcs_gate2_select_test;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_other_rst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0]  line = 4'h0;
  logic        o_wb_ack;
  logic [31:0] o_wb_dat;
  logic [7:0]  o_gate2_terms;
  logic [7:0]  o_gate2_input_select;
  logic [31:0] rd;
  int          bad_count = 0;
  int          n_tests = 0;

  always #20 i_clk = ~i_clk;

  glcs_gate2_select dut (
    .i_clk                (i_clk),
    .i_sys_rst            (i_sys_rst),
    .i_other_rst          (i_other_rst),
    .i_wb_cyc             (cyc),
    .i_wb_stb             (stb),
    .i_wb_we              (we),
    .i_wb_adr             (adr),
    .i_wb_sel             (sel),
    .i_wb_dat             (wdat),
    .i_cell_input_line    (line),
    .o_wb_ack             (o_wb_ack),
    .o_wb_dat             (o_wb_dat),
    .o_gate2_terms        (o_gate2_terms),
    .o_gate2_input_select (o_gate2_input_select)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle; the previous call released on an edge, so one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask : wb

  // Terms lag the select register by one cycle
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask : settle

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // Table: select, lines, expected terms
  // ---------------------------------------------------------------
  localparam int NR = 15;
  logic [7:0] t_sel [NR] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20, 8'h10, 8'h10, 8'h08,
                             8'h04, 8'h02, 8'h01, 8'h01, 8'hff, 8'hff, 8'h00};
  logic [3:0] t_lin [NR] = '{4'h8, 4'h7, 4'h0, 4'h8, 4'h4, 4'h0, 4'h4, 4'h2,
                             4'h0, 4'h1, 4'h0, 4'h1, 4'ha, 4'h5, 4'hf};
  logic [7:0] t_exp [NR] = '{8'h80, 8'h00, 8'h40, 8'h00, 8'h20, 8'h10, 8'h00, 8'h08,
                             8'h04, 8'h02, 8'h01, 8'h00, 8'h99, 8'h66, 8'h00};

  initial begin
    #200us;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk(o_gate2_input_select, 8'h00);
    chk(o_gate2_terms, 8'h00);
    $display("test reset done");
    for (int i = 0; i < NR; i++) begin
      wb(1'b1, 4'h0, 4'h1, {24'h0, t_sel[i]}, rd);
      line <= t_lin[i];
      settle();
      chk(o_gate2_terms, t_exp[i]);
      wb(1'b0, 4'h0, 4'hf, 32'h0, rd);
      chk(rd, {24'h0, t_sel[i]});
    end
    $display("test table done");
    // Byte lane 0 off: write must not land
    wb(1'b1, 4'h0, 4'he, 32'h0000_005a, rd);
    settle();
    chk(o_gate2_input_select, 8'h00);
    // Unmapped word reads zero, write there is dropped
    wb(1'b1, 4'h8, 4'hf, 32'hffff_ffff, rd);
    wb(1'b0, 4'h8, 4'hf, 32'h0, rd);
    chk(rd, 32'h0);
    chk(o_gate2_input_select, 8'h00);
    $display("test refused done");
    // Status shows lines and terms
    wb(1'b1, 4'h0, 4'h1, 32'h0000_00c3, rd);
    line <= 4'h9;
    settle();
    wb(1'b0, 4'h4, 4'hf, 32'h0, rd);
    chk(rd, 32'h0000_8209);
    // Status is read-only: a write there leaves the selection alone
    wb(1'b1, 4'h4, 4'hf, 32'h0000_00ff, rd);
    settle();
    chk(o_gate2_input_select, 8'hc3);
    $display("test status done");
    // Other resets keep the select bits
    @(posedge i_clk);
    i_other_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_other_rst <= 1'b0;
    settle();
    chk(o_gate2_input_select, 8'hc3);
    wb(1'b0, 4'h0, 4'hf, 32'h0, rd);
    chk(rd, 32'h0000_00c3);
    $display("test other reset done");
    // Power-on reset mid-run clears to the chosen value
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    settle();
    chk(o_gate2_input_select, 8'h00);
    chk(o_gate2_terms, 8'h00);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : glcs_gate2_select_test

`default_nettype wire
